// ---- hdl/crcu_pkg.sv ----
// constants, types and shared helpers of the crc calculation unit
// assumes a 32-bit axi4-lite slave port and a single system clock
package crcu_pkg;

	typedef logic [31:0] crcu_word_t;

	// register byte offsets
	localparam logic [7:0] CRCU_OFS_DATA = 8'h00;
	localparam logic [7:0] CRCU_OFS_CTRL = 8'h04;
	localparam logic [7:0] CRCU_OFS_POLY = 8'h08;
	localparam logic [7:0] CRCU_OFS_SEED = 8'h0C;
	localparam logic [7:0] CRCU_OFS_XOR = 8'h10;
	localparam logic [7:0] CRCU_OFS_CLKG = 8'h14;

	// reset values
	localparam crcu_word_t CRCU_RST_DATA = 32'hFFFFFFFF;
	localparam crcu_word_t CRCU_RST_SEED = 32'hFFFFFFFF;
	localparam crcu_word_t CRCU_RST_XOR = 32'h00000000;
	localparam crcu_word_t CRCU_RST_CLKG = 32'h00000001;
	localparam logic [1:0] CRCU_RST_POLY = 2'h0;
	localparam logic [1:0] CRCU_RST_INPUT_BIT_REVERSE = 2'h0;
	localparam logic CRCU_RST_OUTPUT_BIT_REVERSE = 1'b0;

	// field positions
	localparam int CRCU_CTRL_SOFT_BIT = 0;
	localparam int CRCU_CTRL_INPUT_BIT_REVERSE_LO = 1;
	localparam int CRCU_CTRL_OUTPUT_BIT_REVERSE_BIT = 3;
	localparam int CRCU_CTRL_BUSY_BIT = 4;
	localparam int CRCU_CLKG_BIT = 21;

	// polynomial choice codes and generators
	localparam logic [1:0] CRCU_POLY_32 = 2'h0;
	localparam logic [1:0] CRCU_POLY_16 = 2'h1;
	localparam logic [1:0] CRCU_POLY_8 = 2'h2;
	localparam crcu_word_t CRCU_GEN_32 = 32'h04C11DB7;
	localparam crcu_word_t CRCU_GEN_16 = 32'h00001021;
	localparam crcu_word_t CRCU_GEN_8 = 32'h00000007;

	// input reversal codes
	localparam logic [1:0] CRCU_REV_NONE = 2'h0;
	localparam logic [1:0] CRCU_REV_BYTE = 2'h1;
	localparam logic [1:0] CRCU_REV_HALF = 2'h2;
	localparam logic [1:0] CRCU_REV_WORD = 2'h3;

	// access size codes and cycles (one byte per cycle) per size
	localparam logic [1:0] CRCU_SZ_BYTE = 2'h0;
	localparam logic [1:0] CRCU_SZ_HALF = 2'h1;
	localparam logic [1:0] CRCU_SZ_WORD = 2'h2;
	localparam logic [2:0] CRCU_CYC_BYTE = 3'h1;
	localparam logic [2:0] CRCU_CYC_HALF = 3'h2;
	localparam logic [2:0] CRCU_CYC_WORD = 3'h4;

	localparam logic [1:0] CRCU_RESP_OKAY = 2'h0;
	localparam logic [1:0] CRCU_RESP_SLVERR = 2'h2;

	// left shift that moves a narrow crc up to bit 31; reserved code acts as 32-bit
	function automatic logic [4:0] crcu_shift(input logic [1:0] sel);
		crcu_shift = (sel == CRCU_POLY_16) ? 5'h10 : (sel == CRCU_POLY_8) ? 5'h18 : 5'h00;
	endfunction : crcu_shift

	function automatic crcu_word_t crcu_gen(input logic [1:0] sel);
		crcu_gen = (sel == CRCU_POLY_16) ? CRCU_GEN_16 : (sel == CRCU_POLY_8) ? CRCU_GEN_8 : CRCU_GEN_32;
	endfunction : crcu_gen

endpackage : crcu_pkg

// ---- hdl/crcu_byte_step.sv ----
// one byte of crc folding, msb first, for the selected polynomial width
// purely combinational; the caller registers the result
`timescale 1ns/10ps
module crcu_byte_step (
	input wire crcu_pkg::crcu_word_t crc_i,
	input wire logic [7:0] byte_i,
	input wire logic [1:0] poly_choice_i,
	output crcu_pkg::crcu_word_t next_o
);
	import crcu_pkg::*;

	// narrow crcs are lifted to bit 31 so one loop serves all three widths
	always_comb begin
		crcu_word_t acc;
		crcu_word_t gen;
		logic [4:0] sh;
		sh = crcu_shift(poly_choice_i);
		gen = crcu_gen(poly_choice_i) << sh;
		acc = (crc_i << sh) ^ {byte_i, 24'h000000};
		for (int i = 0; i < 8; i++) begin
			acc = acc[31] ? ((acc << 1) ^ gen) : (acc << 1);
		end
		next_o = acc >> sh;
	end

endmodule : crcu_byte_step

// ---- hdl/crcu_top.sv ----
// crc calculation unit with its axi4-lite register slave
// assumes one 10 MHz system clock and a master that honours the busy flag
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
module crcu_top (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire crcu_pkg::crcu_word_t s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output crcu_pkg::crcu_word_t s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	import crcu_pkg::*;

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] aw_addr_q;
	crcu_word_t w_data_q, rdata_q;
	logic [3:0] w_strb_q;

	crcu_word_t crc_q, seed_q, xor_q, clkg_q, din_q;
	logic [1:0] poly_choice_q, input_bit_reverse_q;
	logic output_bit_reverse_q, soft_rst_q;
	logic [2:0] cnt_q;

	// write side decode
	wire wr_go = !awready_q && !wready_q && !bvalid_q;
	wire [7:0] wr_ofs = {aw_addr_q[7:2], 2'b00};
	wire wr_hit = (wr_ofs <= CRCU_OFS_CLKG);
	wire crcu_word_t wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
		{8{w_strb_q[0]}}};
	wire wr_data = wr_go && wr_ofs == CRCU_OFS_DATA;
	wire wr_ctrl = wr_go && wr_ofs == CRCU_OFS_CTRL && w_strb_q[0];
	wire wr_poly = wr_go && wr_ofs == CRCU_OFS_POLY && w_strb_q[0];
	wire wr_seed = wr_go && wr_ofs == CRCU_OFS_SEED;
	wire wr_xor = wr_go && wr_ofs == CRCU_OFS_XOR;
	wire wr_clkg = wr_go && wr_ofs == CRCU_OFS_CLKG;

	wire calc_busy_flag = (cnt_q != 3'h0);
	wire gate_on = clkg_q[CRCU_CLKG_BIT];
	// a write that lands while busy or gated off is dropped, bus still answers okay
	wire data_go = wr_data && !calc_busy_flag && gate_on && !soft_rst_q;

	// access size from the byte lanes; the value is taken from its own lanes
	wire [1:0] wr_size = (w_strb_q == 4'hF) ? CRCU_SZ_WORD :
		(w_strb_q == 4'h3 || w_strb_q == 4'hC) ? CRCU_SZ_HALF : CRCU_SZ_BYTE;
	wire [7:0] wr_byte = w_strb_q[0] ? w_data_q[7:0] : w_strb_q[1] ? w_data_q[15:8] :
		w_strb_q[2] ? w_data_q[23:16] : w_data_q[31:24];
	wire [15:0] wr_half = w_strb_q[0] ? w_data_q[15:0] : w_data_q[31:16];
	wire crcu_word_t din_al = (wr_size == CRCU_SZ_WORD) ? w_data_q :
		(wr_size == CRCU_SZ_HALF) ? {wr_half, 16'h0000} : {wr_byte, 24'h000000};
	wire [2:0] wr_cycles = (wr_size == CRCU_SZ_WORD) ? CRCU_CYC_WORD :
		(wr_size == CRCU_SZ_HALF) ? CRCU_CYC_HALF : CRCU_CYC_BYTE;

	// reversal span never exceeds the access size
	wire [1:0] size_span = wr_size + 2'h1;
	wire [1:0] rev_eff = (input_bit_reverse_q == CRCU_REV_NONE) ? CRCU_REV_NONE :
		(input_bit_reverse_q > size_span) ? size_span : input_bit_reverse_q;

	crcu_word_t rev_byte, rev_half, rev_word, crc_rev;
	for (genvar i = 0; i < 32; i++) begin : g_rev
		assign rev_byte[i] = din_al[(i / 8) * 8 + 7 - (i % 8)];
		assign rev_half[i] = din_al[(i / 16) * 16 + 15 - (i % 16)];
		assign rev_word[i] = din_al[31 - i];
		assign crc_rev[i] = crc_q[31 - i];
	end

	wire crcu_word_t din_rev = (rev_eff == CRCU_REV_BYTE) ? rev_byte :
		(rev_eff == CRCU_REV_HALF) ? rev_half :
		(rev_eff == CRCU_REV_WORD) ? rev_word : din_al;

	// polynomial width view of the accumulator
	wire [4:0] sh = crcu_shift(poly_choice_q);
	wire crcu_word_t wmask_poly = 32'hFFFFFFFF >> sh;
	wire crcu_word_t seed_eff = seed_q & wmask_poly;
	wire crcu_word_t out_ord = output_bit_reverse_q ? (crc_rev >> sh) : crc_q;
	wire crcu_word_t result = (out_ord ^ xor_q) & wmask_poly;

	crcu_word_t step_out;
	crcu_byte_step crcu_byte_step_inst (
		.crc_i(crc_q),
		.byte_i(din_q[31:24]),
		.poly_choice_i(poly_choice_q),
		.next_o(step_out)
	);

	// read side decode
	wire [7:0] rd_ofs = {s_axi_araddr_i[7:2], 2'b00};
	wire crcu_word_t ctrl_rd = {27'h0000000, calc_busy_flag, output_bit_reverse_q,
		input_bit_reverse_q, soft_rst_q};
	wire crcu_word_t rd_mux = (rd_ofs == CRCU_OFS_DATA) ? result :
		(rd_ofs == CRCU_OFS_CTRL) ? ctrl_rd :
		(rd_ofs == CRCU_OFS_POLY) ? {30'h00000000, poly_choice_q} :
		(rd_ofs == CRCU_OFS_SEED) ? seed_q :
		(rd_ofs == CRCU_OFS_XOR) ? xor_q :
		(rd_ofs == CRCU_OFS_CLKG) ? clkg_q : 32'h00000000;
	wire rd_hit = (rd_ofs <= CRCU_OFS_CLKG);
	wire ar_take = s_axi_arvalid_i && arready_q;

	// axi write address and data are caught independently, then applied together
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && awready_q) begin
				awready_q <= 1'b0;
				aw_addr_q <= s_axi_awaddr_i;
			end else if (wr_go) begin
				awready_q <= 1'b1;
			end
			if (s_axi_wvalid_i && wready_q) begin
				wready_q <= 1'b0;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
			end else if (wr_go) begin
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= CRCU_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? CRCU_RESP_OKAY : CRCU_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= CRCU_RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? CRCU_RESP_OKAY : CRCU_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seed_q <= CRCU_RST_SEED;
			xor_q <= CRCU_RST_XOR;
			clkg_q <= CRCU_RST_CLKG;
			poly_choice_q <= CRCU_RST_POLY;
			input_bit_reverse_q <= CRCU_RST_INPUT_BIT_REVERSE;
			output_bit_reverse_q <= CRCU_RST_OUTPUT_BIT_REVERSE;
		end else begin
			if (wr_seed)
				seed_q <= (seed_q & ~wmask) | (w_data_q & wmask);
			if (wr_xor)
				xor_q <= (xor_q & ~wmask) | (w_data_q & wmask);
			if (wr_clkg)
				clkg_q <= (clkg_q & ~wmask) | (w_data_q & wmask);
			if (wr_poly)
				poly_choice_q <= w_data_q[1:0];
			if (wr_ctrl) begin
				input_bit_reverse_q <= w_data_q[CRCU_CTRL_INPUT_BIT_REVERSE_LO +: 2];
				output_bit_reverse_q <= w_data_q[CRCU_CTRL_OUTPUT_BIT_REVERSE_BIT];
			end
		end
	end

	// soft reset is a one-cycle pulse; writing 0 has no effect
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= wr_ctrl && w_data_q[CRCU_CTRL_SOFT_BIT];
	end

	// engine: one byte per cycle, msb byte first; a gated-off unit holds its state unless a soft reset reloads the seed
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crc_q <= CRCU_RST_DATA;
			din_q <= 32'h00000000;
			cnt_q <= 3'h0;
		end else if (soft_rst_q) begin
			crc_q <= seed_eff;
			cnt_q <= 3'h0;
		end else if (data_go) begin
			din_q <= din_rev;
			cnt_q <= wr_cycles;
		end else if (calc_busy_flag && gate_on) begin
			crc_q <= step_out;
			din_q <= {din_q[23:0], 8'h00};
			cnt_q <= cnt_q - 3'h1;
		end
	end

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_word_start;
		data_go && wr_size == CRCU_SZ_WORD;
	endsequence
	sequence s_half_start;
		data_go && wr_size == CRCU_SZ_HALF;
	endsequence
	// busy is sampled high on the n edges that fold a byte, low on the edge after them
	sequence s_run4;
		(gate_on && !soft_rst_q)[*4];
	endsequence

	property p_word_cycles;
		s_word_start ##1 s_run4 |=> !calc_busy_flag;
	endproperty
	a_word_cycles: assert property (p_word_cycles) else $error("word crc not done in 4 cycles");

	property p_half_cycles;
		s_half_start ##1 (gate_on && !soft_rst_q)[*2] |=> !calc_busy_flag;
	endproperty
	a_half_cycles: assert property (p_half_cycles) else $error("half crc not done in 2 cycles");

	property p_byte_cycles;
		(data_go && wr_size == CRCU_SZ_BYTE) ##1 (gate_on && !soft_rst_q) |=> !calc_busy_flag;
	endproperty
	a_byte_cycles: assert property (p_byte_cycles) else $error("byte crc not done in 1 cycle");

	property p_busy_set;
		data_go |=> calc_busy_flag && cnt_q == $past(wr_cycles);
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not raised by data write");

	property p_ignore_busy;
		wr_data && calc_busy_flag && gate_on && !soft_rst_q |=> cnt_q == $past(cnt_q) - 3'h1;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) else $error("busy write disturbed calc");

	property p_soft_pulse;
		soft_rst_q |=> !soft_rst_q && crc_q == $past(seed_eff) && !calc_busy_flag;
	endproperty
	a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset not one clean pulse");

	property p_gate_hold;
		!gate_on && !soft_rst_q |=> $stable(crc_q) && $stable(cnt_q);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gated unit changed state");

	property p_narrow_result;
		poly_choice_q == CRCU_POLY_8 |-> result[31:8] == 24'h000000;
	endproperty
	a_narrow_result: assert property (p_narrow_result) else $error("crc-8 result too wide");

	property p_rev_span;
		data_go && wr_size == CRCU_SZ_BYTE |-> rev_eff <= CRCU_REV_BYTE;
	endproperty
	a_rev_span: assert property (p_rev_span) else $error("byte write reversed beyond byte");

	// a data port write of any width is answered okay one cycle after it is applied
	property p_write_answer;
		wr_data |=> bvalid_q && bresp_q == CRCU_RESP_OKAY && awready_q && wready_q;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("data write not answered");

endmodule : crcu_top

// ---- testbench/crcu_axi_master.sv ----
// axi4-lite master model standing in for the processor or dma side
// assumes the crcu_top slave and one clock; each task is entered just after a rising edge
`timescale 1ns/10ps
module crcu_axi_master (
	input wire logic sys_clk_i,
	output logic [7:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output crcu_pkg::crcu_word_t wdata_o,
	output logic [3:0] wstrb_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [7:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire crcu_pkg::crcu_word_t rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	import crcu_pkg::*;
	// response readies stay high, so no ready edge can collide with a new request
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, araddr_o, arvalid_o} = '0;
		bready_o = 1'b1;
		rready_o = 1'b1;
	end
	task automatic write_reg(input logic [7:0] a, input crcu_word_t d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		awaddr_o <= a;
		awvalid_o <= 1'b1;
		wdata_o <= d;
		wstrb_o <= s;
		wvalid_o <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			if (aw && awready_i) begin
				aw = 1'b0;
				awvalid_o <= 1'b0;
			end
			// released data shows its inverse so a stale word never looks live
			if (w && wready_i) begin
				w = 1'b0;
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
		end while (aw || w || !bvalid_i);
		r = bresp_i;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] a, output crcu_word_t d, output logic [1:0] r);
		logic ar;
		ar = 1'b1;
		araddr_o <= a;
		arvalid_o <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			if (ar && arready_i) begin
				ar = 1'b0;
				arvalid_o <= 1'b0;
			end
		end while (ar || !rvalid_i);
		d = rdata_i;
		r = rresp_i;
	endtask : read_reg
endmodule : crcu_axi_master

// ---- testbench/crc_calc_unit_bench.sv ----
// self-checking bench for crcu_top driven through the axi4-lite master model
// assumes a 10 MHz clock and the register offsets of crcu_pkg
`timescale 1ns/10ps
module crc_calc_unit_bench;
	import crcu_pkg::*;
	logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp, pl, ri;
	logic ro;
	crcu_word_t wdata, rdata, rv, crc_m, seed, xr, d;
	logic [3:0] strbs [3] = '{4'h1, 4'h3, 4'hF};
	int err_total, num_checks, k;
	crcu_top crcu_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));
	crcu_axi_master crcu_axi_master_inst (.sys_clk_i(clk), .awaddr_o(awaddr),
		.awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
		.wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
		.bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
		.rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic int wid();
		return (pl == CRCU_POLY_16) ? 16 : (pl == CRCU_POLY_8) ? 8 : 32;
	endfunction : wid
	function automatic crcu_word_t msk();
		return 32'hFFFFFFFF >> (32 - wid());
	endfunction : msk
	// msb-first fold; reversal span is the smaller of the selected span and the access size
	function automatic crcu_word_t fold(input crcu_word_t c, input crcu_word_t v, input int nb);
		int sp;
		crcu_word_t e;
		crcu_word_t g;
		g = (pl == CRCU_POLY_16) ? CRCU_GEN_16 : (pl == CRCU_POLY_8) ? CRCU_GEN_8 : CRCU_GEN_32;
		sp = (ri == 2'h0) ? 0 : ((8 << (ri - 1)) < 8 * nb) ? (8 << (ri - 1)) : 8 * nb;
		e = v;
		for (int i = 0; i < 8 * nb; i++) begin
			if (sp > 0) e[i] = v[i - i % sp + sp - 1 - i % sp];
		end
		for (int b = nb - 1; b >= 0; b--) begin
			c = c ^ (crcu_word_t'(e[8 * b +: 8]) << (wid() - 8));
			for (int j = 0; j < 8; j++) c = c[wid() - 1] ? ((c << 1) ^ g) : (c << 1);
		end
		return c & msk();
	endfunction : fold
	function automatic crcu_word_t res(input crcu_word_t c);
		crcu_word_t r;
		r = c;
		for (int i = 0; i < wid(); i++) begin
			if (ro) r[i] = c[wid() - 1 - i];
		end
		return (r ^ xr) & msk();
	endfunction : res
	task automatic check(input string n, input crcu_word_t e, input crcu_word_t g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input crcu_word_t v, input logic [3:0] s = 4'hF);
		crcu_axi_master_inst.write_reg(a, v, s, rsp);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input crcu_word_t e);
		crcu_axi_master_inst.read_reg(a, rv, rsp);
		check($sformatf("register %h", a), e, rv);
	endtask : rchk
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			crcu_axi_master_inst.read_reg(CRCU_OFS_CTRL, rv, rsp);
			n++;
		end while (rv[4] !== 1'b0 && n < 8);
		check("busy flag", 32'h0, {31'h0, rv[4]});
	endtask : wait_idle
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
	initial begin
		err_total = 0;
		num_checks = 0;
		void'($urandom(90271));
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk(CRCU_OFS_DATA, 32'hFFFFFFFF);
		rchk(CRCU_OFS_CTRL, 32'h0);
		rchk(CRCU_OFS_POLY, 32'h0);
		rchk(CRCU_OFS_SEED, 32'hFFFFFFFF);
		rchk(CRCU_OFS_XOR, 32'h0);
		rchk(CRCU_OFS_CLKG, 32'h1);
		crcu_axi_master_inst.read_reg(8'h18, rv, rsp);
		check("unmapped rresp", 32'h2, {30'h0, rsp});
		wr(8'h18, 32'h0);
		check("unmapped bresp", 32'h2, {30'h0, rsp});
		// gate still off: a data write must leave the result alone
		wr(CRCU_OFS_DATA, $urandom());
		rchk(CRCU_OFS_DATA, 32'hFFFFFFFF);
		wr(CRCU_OFS_CLKG, 32'h00200001);
		$display("test reset_and_gate done");
		// configuration only changes between calculations
		for (int c = 0; c < 24; c++) begin
			pl = 2'(c % 3);
			ri = 2'(c / 3 % 4);
			ro = 1'(c / 12);
			seed = $urandom();
			xr = $urandom();
			wr(CRCU_OFS_POLY, {30'h0, pl});
			wr(CRCU_OFS_SEED, seed);
			wr(CRCU_OFS_XOR, xr);
			wr(CRCU_OFS_CTRL, {28'h0, ro, ri, 1'b1});
			crc_m = seed & msk();
			rchk(CRCU_OFS_CTRL, {28'h0, ro, ri, 1'b0});
			repeat (3) begin
				k = $urandom_range(2, 0);
				d = $urandom();
				wr(CRCU_OFS_DATA, d, strbs[k]);
				crc_m = fold(crc_m, d, 1 << k);
				wait_idle();
			end
			rchk(CRCU_OFS_DATA, res(crc_m));
		end
		$display("test modes done");
		// reserved polynomial code runs as the 32-bit generator
		pl = 2'h3;
		ri = 2'h0;
		ro = 1'b0;
		xr = 32'h0;
		wr(CRCU_OFS_POLY, {30'h0, pl});
		rchk(CRCU_OFS_POLY, 32'h3);
		wr(CRCU_OFS_XOR, 32'h0);
		wr(CRCU_OFS_CTRL, 32'h1);
		crc_m = seed;
		d = $urandom();
		wr(CRCU_OFS_DATA, d, 4'h1);
		crc_m = fold(crc_m, d, 1);
		rchk(CRCU_OFS_CTRL, 32'h0);
		d = $urandom();
		wr(CRCU_OFS_DATA, d);
		crc_m = fold(crc_m, d, 4);
		rchk(CRCU_OFS_CTRL, 32'h10);
		wait_idle();
		d = $urandom();
		wr(CRCU_OFS_DATA, d);
		crc_m = fold(crc_m, d, 4);
		// deliberately lands while busy and must be dropped
		wr(CRCU_OFS_DATA, ~d);
		check("busy write bresp", 32'h0, {30'h0, rsp});
		wait_idle();
		rchk(CRCU_OFS_DATA, res(crc_m));
		$display("test busy done");
		finish_test();
	end
endmodule : crc_calc_unit_bench
